// [core/vib_ctrl.sv]
`timescale 1ns/1ps
`include "vib_params.svh"
module vib_ctrl
    import vib_pkg::*;
(
    // Clock and reset
    input  wire logic        i_clk_sys,
    input  wire logic        i_rst,
    // Status and control word
    input  wire logic [31:0] i_fp_status_control_reg,
    // Instruction issue
    input  wire logic        i_issue,
    input  wire vib_instr_t  i_instr,
    // Results
    output logic             o_busy,
    output logic             o_bounce,
    output logic             o_trap,
    output logic             o_exc_state,
    output logic             o_iter_valid,
    output vib_iter_t        o_iter
);
    // ==========================================================
    // Decode helpers
    // ==========================================================
    function automatic logic [4:0] step_reg(input logic [4:0] r, input logic [2:0] inc,
                                            input logic dbl);
        logic [4:0] m;
        logic [4:0] s;
        m = dbl ? `VIB_DP_BANK_MASK : `VIB_SP_BANK_MASK;
        s = r + {2'h0, inc};
        step_reg = (r & m) | (s & ~m);
    endfunction

    function automatic logic sys_exempt(input vib_instr_t ins);
        sys_exempt = (ins.op == VIB_OP_MOVE_TO || ins.op == VIB_OP_MOVE_FROM) &&
                     (ins.sys_reg == `VIB_SYS_EXC || ins.sys_reg == `VIB_SYS_INST ||
                      ins.sys_reg == `VIB_SYS_ID);
    endfunction

    logic [1:0] stride_f;
    logic [2:0] vector_length_field;
    logic [2:0] inc;
    logic       no_bounce_fast_mode;
    logic       any_enable;
    logic       sub_a, sub_b, spec_a, spec_b;

    assign stride_f            = i_fp_status_control_reg[`VIB_STRIDE_HI:`VIB_STRIDE_LO];
    assign vector_length_field = i_fp_status_control_reg[`VIB_LEN_HI:`VIB_LEN_LO];
    assign any_enable          = |i_fp_status_control_reg[`VIB_EN_HI:`VIB_EN_LO];
    assign no_bounce_fast_mode = i_fp_status_control_reg[`VIB_DN_BIT] &
                                 i_fp_status_control_reg[`VIB_FZ_BIT] & ~any_enable;
    // Stride 00 steps 1, 11 steps 2
    assign inc = (stride_f == `VIB_STRIDE_TWO) ? 3'h2 : 3'h1;

    vib_operand_class u_cls_a (
        .i_val       (i_instr.opa),
        .i_dbl       (i_instr.dbl),
        .o_subnormal (sub_a),
        .o_special   (spec_a)
    );
    vib_operand_class u_cls_b (
        .i_val       (i_instr.opb),
        .i_dbl       (i_instr.dbl),
        .o_subnormal (sub_b),
        .o_special   (spec_b)
    );

    // ==========================================================
    // Sequencer
    // ==========================================================
    vib_state_t state_q, state_d;
    logic       exc_q, exc_d;
    logic [2:0] left_q, left_d;
    logic [2:0] inc_q, inc_d;
    vib_iter_t  iter_q, iter_d;
    logic       ivld_q, ivld_d;
    logic       bounce_q, bounce_d;
    logic       trap_q, trap_d;
    logic       unsup;
    logic       arith;

    always_comb begin
        state_d  = state_q;
        exc_d    = exc_q;
        left_d   = left_q;
        inc_d    = inc_q;
        iter_d   = iter_q;
        ivld_d   = 1'b0;
        bounce_d = 1'b0;
        trap_d   = 1'b0;
        arith    = (i_instr.op == VIB_OP_ARITH);
        unsup    = arith && !no_bounce_fast_mode &&
                   (sub_a | sub_b | spec_a | spec_b);
        unique case (state_q)
            VIB_IDLE, VIB_EXC: begin
                if (i_issue) begin
                    if (exc_q && !sys_exempt(i_instr)) begin
                        // Trigger refused, nothing executed
                        bounce_d = 1'b1;
                        trap_d   = any_enable;
                        exc_d    = 1'b0;
                        state_d  = VIB_IDLE;
                    end else if (unsup) begin
                        bounce_d = 1'b1;
                        trap_d   = any_enable;
                    end else begin
                        if (arith && i_instr.pot_exc && !no_bounce_fast_mode) begin
                            exc_d   = 1'b1;
                        end
                        iter_d.dst   = i_instr.dst;
                        iter_d.src_a = i_instr.src_a;
                        iter_d.src_b = i_instr.src_b;
                        iter_d.dbl   = i_instr.dbl;
                        ivld_d       = arith;
                        inc_d        = inc;
                        if (arith && i_instr.vec_dst && vector_length_field != 3'h0) begin
                            // Length code plus one iterations
                            left_d      = vector_length_field;
                            iter_d.last = 1'b0;
                            state_d     = VIB_ITER;
                        end else begin
                            iter_d.last = 1'b1;
                            state_d     = exc_d ? VIB_EXC : VIB_IDLE;
                        end
                    end
                end
            end
            VIB_ITER: begin
                iter_d.dst   = step_reg(iter_q.dst, inc_q, iter_q.dbl);
                iter_d.src_a = step_reg(iter_q.src_a, inc_q, iter_q.dbl);
                iter_d.src_b = step_reg(iter_q.src_b, inc_q, iter_q.dbl);
                iter_d.last  = (left_q == 3'h1);
                ivld_d       = 1'b1;
                left_d       = left_q - 3'h1;
                if (left_q == 3'h1) begin
                    state_d = exc_q ? VIB_EXC : VIB_IDLE;
                end
            end
            default: state_d = VIB_IDLE;
        endcase
    end

    always_ff @(posedge i_clk_sys) begin
        if (i_rst) begin
            state_q  <= VIB_IDLE;
            exc_q    <= 1'b0;
            left_q   <= 3'h0;
            inc_q    <= 3'h1;
            iter_q   <= '0;
            ivld_q   <= 1'b0;
            bounce_q <= 1'b0;
            trap_q   <= 1'b0;
        end else begin
            state_q  <= state_d;
            exc_q    <= exc_d;
            left_q   <= left_d;
            inc_q    <= inc_d;
            iter_q   <= iter_d;
            ivld_q   <= ivld_d;
            bounce_q <= bounce_d;
            trap_q   <= trap_d;
        end
    end

    // Busy registered so the output comes from a flip-flop
    logic busy_q;
    always_ff @(posedge i_clk_sys) begin
        if (i_rst) begin
            busy_q <= 1'b0;
        end else begin
            busy_q <= (state_d == VIB_ITER);
        end
    end

    assign o_busy       = busy_q;
    assign o_bounce     = bounce_q;
    assign o_trap       = trap_q;
    assign o_exc_state  = exc_q;
    assign o_iter_valid = ivld_q;
    assign o_iter       = iter_q;

    // ==========================================================
    // Checks
    // ==========================================================
    a_stride_two: assert property (@(posedge i_clk_sys) disable iff (i_rst)
        (ivld_q && !iter_q.last && state_q == VIB_ITER && inc_q == 3'h2 && !iter_q.dbl
         && iter_q.dst[2:0] < 3'h6) |=> (iter_q.dst == $past(iter_q.dst) + 5'h2))
        else $error("stride two step wrong");
    a_stride_one: assert property (@(posedge i_clk_sys) disable iff (i_rst)
        (state_q == VIB_ITER && inc_q == 3'h1 && !iter_q.dbl && iter_q.dst[2:0] != 3'h7)
        |=> (iter_q.dst == $past(iter_q.dst) + 5'h1))
        else $error("stride one step wrong");
    a_bank_kept: assert property (@(posedge i_clk_sys) disable iff (i_rst)
        (state_q == VIB_ITER && !iter_q.dbl) |=> (iter_q.dst[4:3] == $past(iter_q.dst[4:3])))
        else $error("vector left its bank");
    a_len_four: assert property (@(posedge i_clk_sys) disable iff (i_rst)
        (state_q != VIB_ITER && state_d == VIB_ITER && left_d == 3'h3)
        |=> ivld_q ##1 ivld_q ##1 ivld_q ##1 (ivld_q && iter_q.last))
        else $error("length 011 not four iterations");
    a_scalar_one: assert property (@(posedge i_clk_sys) disable iff (i_rst)
        (state_q != VIB_ITER && ivld_d && state_d != VIB_ITER) |=> iter_q.last)
        else $error("scalar not single write");
    a_exc_enter: assert property (@(posedge i_clk_sys) disable iff (i_rst)
        (i_issue && state_q != VIB_ITER && !exc_q && !unsup && arith && i_instr.pot_exc
         && !no_bounce_fast_mode) |=> exc_q)
        else $error("exceptional state not entered");
    a_trigger_bounce: assert property (@(posedge i_clk_sys) disable iff (i_rst)
        (i_issue && exc_q && state_q != VIB_ITER && !sys_exempt(i_instr))
        |=> (o_bounce && !o_iter_valid && !exc_q))
        else $error("trigger not bounced");
    a_exempt_pass: assert property (@(posedge i_clk_sys) disable iff (i_rst)
        (i_issue && exc_q && state_q != VIB_ITER && sys_exempt(i_instr)) |=> !o_bounce)
        else $error("system move bounced");
    a_fast_nobounce: assert property (@(posedge i_clk_sys) disable iff (i_rst)
        (i_issue && !exc_q && state_q != VIB_ITER && no_bounce_fast_mode) |=> !o_bounce)
        else $error("bounce in fast mode");
    a_trap_enable: assert property (@(posedge i_clk_sys) disable iff (i_rst)
        o_trap |-> o_bounce)
        else $error("trap without bounce");

    c_vector: cover property (@(posedge i_clk_sys)
        state_q == VIB_ITER ##1 (ivld_q && iter_q.last));
    c_bounce: cover property (@(posedge i_clk_sys) o_bounce && !o_exc_state);
    c_exempt: cover property (@(posedge i_clk_sys) exc_q && i_issue && sys_exempt(i_instr));
endmodule

// [core/vib_operand_class.sv]
`timescale 1ns/1ps
`include "vib_params.svh"
module vib_operand_class
    import vib_pkg::*;
(
    // Operand
    input  wire logic [63:0] i_val,
    input  wire logic        i_dbl,
    // Class
    output logic             o_subnormal,
    output logic             o_special
);
    logic [10:0] exp_v;
    logic        frac_nz;
    logic        exp_max;

    always_comb begin
        if (i_dbl) begin
            exp_v   = i_val[`VIB_DP_EXP_HI:`VIB_DP_EXP_LO];
            frac_nz = |i_val[`VIB_DP_EXP_LO-1:0];
            exp_max = &i_val[`VIB_DP_EXP_HI:`VIB_DP_EXP_LO];
        end else begin
            exp_v   = {3'h0, i_val[`VIB_SP_EXP_HI:`VIB_SP_EXP_LO]};
            frac_nz = |i_val[`VIB_SP_EXP_LO-1:0];
            exp_max = &i_val[`VIB_SP_EXP_HI:`VIB_SP_EXP_LO];
        end
        // Zero exponent with nonzero fraction
        o_subnormal = (exp_v == 11'h000) && frac_nz;
        // Infinities and NaNs go to support code
        o_special   = exp_max;
    end
endmodule

// [core/vib_params.svh]
`ifndef VIB_PARAMS_SVH
`define VIB_PARAMS_SVH
`define VIB_STRIDE_HI     21
`define VIB_STRIDE_LO     20
`define VIB_LEN_HI        18
`define VIB_LEN_LO        16
`define VIB_DN_BIT        25
`define VIB_FZ_BIT        24
`define VIB_EN_HI         12
`define VIB_EN_LO         8
`define VIB_STRIDE_ONE    2'h0
`define VIB_STRIDE_TWO    2'h3
`define VIB_SYS_EXC       4'h8
`define VIB_SYS_INST      4'h9
`define VIB_SYS_ID        4'h0
`define VIB_SP_BANK_MASK  5'h18
`define VIB_DP_BANK_MASK  5'h1C
`define VIB_SP_EXP_HI     30
`define VIB_SP_EXP_LO     23
`define VIB_DP_EXP_HI     62
`define VIB_DP_EXP_LO     52
`define VIB_CSR_RESET     32'h0000_0000
`endif

// [core/vib_pkg.sv]
package vib_pkg;
    typedef enum logic [1:0] {
        VIB_IDLE = 2'h0,
        VIB_ITER = 2'h1,
        VIB_EXC  = 2'h3
    } vib_state_t;

    typedef enum logic [1:0] {
        VIB_OP_ARITH = 2'h0,
        VIB_OP_MOVE_TO = 2'h1,
        VIB_OP_MOVE_FROM = 2'h2,
        VIB_OP_OTHER = 2'h3
    } vib_op_t;

    typedef struct packed {
        vib_op_t     op;
        logic        dbl;
        logic [4:0]  dst;
        logic [4:0]  src_a;
        logic [4:0]  src_b;
        logic [3:0]  sys_reg;
        logic        pot_exc;
        logic        vec_dst;
        logic [63:0] opa;
        logic [63:0] opb;
    } vib_instr_t;

    typedef struct packed {
        logic [4:0] dst;
        logic [4:0] src_a;
        logic [4:0] src_b;
        logic       dbl;
        logic       last;
    } vib_iter_t;
endpackage

// [verification/vib_ctrl_test.sv]
`timescale 1ns/1ps
module vib_ctrl_test
    import vib_pkg::*;
;
    // ====================
    // Signals and instances
    localparam logic [63:0] VALS [4] = '{64'h1, 64'h7F80_0000, 64'h0, 64'h3F80_0000};
    localparam logic        BNC  [4] = '{1'b1, 1'b1, 1'b0, 1'b0};
    logic        clk_sys, rst, go, ret, issue, busy, bounce, trap, exc, iv;
    logic [31:0] csr;
    vib_instr_t  go_ins, ins;
    vib_iter_t   it;
    int          mismatches, checked;

    vib_host i_vib_host (.i_clk_sys(clk_sys), .i_rst(rst), .i_go(go), .i_go_instr(go_ins),
        .i_ret(ret), .i_bounce(bounce), .o_issue(issue), .o_instr(ins));
    vib_ctrl i_vib_ctrl (.i_clk_sys(clk_sys), .i_rst(rst), .i_fp_status_control_reg(csr),
        .i_issue(issue), .i_instr(ins), .o_busy(busy), .o_bounce(bounce), .o_trap(trap),
        .o_exc_state(exc), .o_iter_valid(iv), .o_iter(it));

    initial begin
        clk_sys = 1'b0;
        forever #5 clk_sys = ~clk_sys;
    end

    // ====================
    // Tasks
    task automatic conclude();
        $display("mismatches=%0d checked=%0d", mismatches, checked);
        if (mismatches == 0 && checked > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask

    task automatic cmp_bit(input logic a, input logic e);
        checked++;
        if (a !== e) begin
            mismatches++;
            $display("ERROR t=%0t got %h exp %h", $time, a, e);
        end
    endtask

    task automatic cmp_reg(input logic [4:0] a, input logic [4:0] e);
        checked++;
        if (a !== e) begin
            mismatches++;
            $display("ERROR t=%0t got %h exp %h", $time, a, e);
        end
    endtask

    function automatic logic [4:0] nth(input logic [4:0] r, input int k, input int s,
                                       input logic dbl);
        // Bank bits kept, only the index inside the bank steps
        if (dbl) return {r[4:2], 2'(int'(r[1:0]) + k * s)};
        return {r[4:3], 3'(int'(r[2:0]) + k * s)};
    endfunction

    function automatic logic [31:0] mk(input logic [1:0] s, input logic [2:0] l,
                                       input logic [4:0] en, input logic fast);
        return {6'h00, fast, fast, 2'h0, s, 1'h0, l, 3'h0, en, 8'h00};
    endfunction

    task automatic send(input vib_instr_t x);
        go_ins = x;
        go = 1'b1;
        @(posedge clk_sys) #1 go = 1'b0;
        @(posedge clk_sys) #1;
    endtask

    task automatic retry();
        // Host notes the bounce one edge after it shows
        @(posedge clk_sys) #1 ret = 1'b1;
        @(posedge clk_sys) #1 ret = 1'b0;
        @(posedge clk_sys) #1;
    endtask

    task automatic run(input vib_instr_t x, input int n, input int s);
        send(x);
        for (int k = 0; k < n; k++) begin
            cmp_bit(iv, 1'b1);
            cmp_bit(bounce, 1'b0);
            cmp_reg(it.dst, nth(x.dst, k, s, x.dbl));
            cmp_reg(it.src_a, nth(x.src_a, k, s, x.dbl));
            cmp_reg(it.src_b, nth(x.src_b, k, s, x.dbl));
            cmp_bit(it.last, k == n - 1);
            cmp_bit(it.dbl, x.dbl);
            cmp_bit(busy, k < n - 1);
            @(posedge clk_sys) #1;
        end
        cmp_bit(iv, 1'b0);
    endtask

    task automatic check_bounce(input vib_instr_t x, input logic b, input logic t);
        send(x);
        cmp_bit(bounce, b);
        cmp_bit(trap, t);
    endtask

    // ====================
    // Watchdog
    initial begin
        #100000;
        mismatches++;
        conclude();
    end

    // ====================
    // Tests
    initial begin
        vib_instr_t b;
        rst = 1'b1;
        go = 1'b0;
        ret = 1'b0;
        csr = 32'h0000_0000;
        go_ins = '0;
        mismatches = 0;
        checked = 0;
        b = '{VIB_OP_ARITH, 1'b0, 5'h08, 5'h10, 5'h18, 4'h0, 1'b0, 1'b1,
              64'h3F80_0000, 64'h3F80_0000};
        repeat (5) @(posedge clk_sys);
        #1 rst = 1'b0;
        cmp_bit(busy, 1'b0);
        cmp_bit(exc, 1'b0);
        for (int s = 0; s < 4; s++) begin
            csr = mk(2'(s), 3'h3, 5'h00, 1'b0);
            run(b, 4, (s == 3) ? 2 : 1);
        end
        for (int l = 0; l < 8; l++) begin
            csr = mk(2'h0, 3'(l), 5'h00, 1'b0);
            run(b, l + 1, 1);
        end
        csr = mk(2'h0, 3'h3, 5'h00, 1'b0);
        b.dst = 5'h0E;
        run(b, 4, 1);
        b = '{VIB_OP_ARITH, 1'b1, 5'h0E, 5'h06, 5'h0A, 4'h0, 1'b0, 1'b1,
              64'h3FF0_0000_0000_0000, 64'h3FF0_0000_0000_0000};
        run(b, 4, 1);
        b.vec_dst = 1'b0;
        run(b, 1, 1);
        csr = mk(2'h0, 3'h0, 5'h00, 1'b0);
        b.pot_exc = 1'b1;
        check_bounce(b, 1'b0, 1'b0);
        cmp_bit(exc, 1'b1);
        for (int i = 0; i < 6; i++) begin
            go_ins = b;
            go_ins.pot_exc = 1'b0;
            go_ins.op = (i < 3) ? VIB_OP_MOVE_TO : VIB_OP_MOVE_FROM;
            go_ins.sys_reg = (i % 3 == 0) ? 4'h8 : ((i % 3 == 1) ? 4'h9 : 4'h0);
            check_bounce(go_ins, 1'b0, 1'b0);
            cmp_bit(exc, 1'b1);
        end
        b.pot_exc = 1'b0;
        check_bounce(b, 1'b1, 1'b0);
        cmp_bit(iv, 1'b0);
        cmp_bit(exc, 1'b0);
        retry();
        cmp_bit(bounce, 1'b0);
        cmp_bit(iv, 1'b1);
        b.pot_exc = 1'b1;
        check_bounce(b, 1'b0, 1'b0);
        go_ins = b;
        go_ins.op = VIB_OP_MOVE_TO;
        go_ins.sys_reg = 4'h1;
        go_ins.pot_exc = 1'b0;
        check_bounce(go_ins, 1'b1, 1'b0);
        check_bounce(b, 1'b0, 1'b0);
        go_ins.op = VIB_OP_OTHER;
        go_ins.sys_reg = 4'h8;
        check_bounce(go_ins, 1'b1, 1'b0);
        b = '{VIB_OP_ARITH, 1'b0, 5'h08, 5'h10, 5'h18, 4'h0, 1'b0, 1'b0,
              64'h3F80_0000, 64'h3F80_0000};
        for (int i = 0; i < 4; i++) begin
            b.opa = VALS[i];
            check_bounce(b, BNC[i], 1'b0);
        end
        csr = mk(2'h0, 3'h0, 5'h01, 1'b0);
        b.opa = VALS[0];
        check_bounce(b, 1'b1, 1'b1);
        csr = mk(2'h0, 3'h0, 5'h00, 1'b1);
        check_bounce(b, 1'b0, 1'b0);
        b.opb = VALS[1];
        check_bounce(b, 1'b0, 1'b0);
        conclude();
    end
endmodule

// [verification/vib_host.sv]
`timescale 1ns/1ps
module vib_host
    import vib_pkg::*;
(
    // Clock and reset
    input  wire logic       i_clk_sys,
    input  wire logic       i_rst,
    // Bench requests
    input  wire logic       i_go,
    input  wire vib_instr_t i_go_instr,
    input  wire logic       i_ret,
    // Device answer
    input  wire logic       i_bounce,
    // Issue side
    output logic            o_issue,
    output vib_instr_t      o_instr
);
    // ====================
    // Issue and retry
    logic       pend_q;
    vib_instr_t held_q;

    always_ff @(posedge i_clk_sys) begin
        o_issue <= 1'b0;
        // Idle bus alternates between the inverse of the last instruction and the instruction itself
        o_instr <= ~o_instr;
        if (i_rst) begin
            pend_q  <= 1'b0;
            o_instr <= '0;
        end else if (i_go) begin
            o_issue <= 1'b1;
            o_instr <= i_go_instr;
            held_q  <= i_go_instr;
        end else if (i_ret && pend_q) begin
            o_issue <= 1'b1;
            o_instr <= held_q;
            pend_q  <= 1'b0;
        end
        if (!i_rst && i_bounce) begin
            pend_q <= 1'b1;
        end
    end
endmodule
